// ===== smf_cmp_filter.sv
// module: two-stage synchroniser and glitch filter for one comparator output
`timescale 1ns/1ps
module smf_cmp_filter #(
    parameter int FILT_CYC = 8
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // comparator
    input wire logic i_cmp_async,
    // results
    output logic o_sync,
    output logic o_filt
);
    localparam int CW = $clog2(FILT_CYC + 1);

    // elaboration check: a zero length would pass every glitch
    if (FILT_CYC < 1)
    begin
        $error("smf_cmp_filter: FILT_CYC must be at least 1");
    end

    typedef struct packed {
        logic meta;
        logic sync;
        logic filt;
        logic [CW-1:0] cnt;
    } smf_flt_s;

    smf_flt_s st_ff;
    smf_flt_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // RL12 two-stage synchroniser
        nxt_st.meta = i_cmp_async;
        nxt_st.sync = st_ff.meta;
        // RL10 glitch filter
        if (st_ff.sync == st_ff.filt)
        begin
            nxt_st.cnt = '0;
        end
        else if (st_ff.cnt == CW'(FILT_CYC - 1))
        begin
            nxt_st.cnt = '0;
            nxt_st.filt = st_ff.sync;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    // rails assumed good at reset; a real low shows after sync plus filter delay
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st_ff <= '{meta: 1'b1, sync: 1'b1, filt: 1'b1, cnt: '0};
        else
            st_ff <= nxt_st;
    end

    assign o_sync = st_ff.sync;
    assign o_filt = st_ff.filt;
endmodule

// ===== smf_cmp_model.sv
// model: analogue comparators on both supply rails, rail levels in mV
`timescale 1ns/1ps
module smf_cmp_model (
    input wire logic i_monitor_enable,
    input wire logic [1:0] i_digital_trip_sel,
    input wire logic [1:0] i_analog_trip_sel,
    input wire logic [15:0] i_dig_mv,
    input wire logic [15:0] i_ana_mv,
    output logic o_digital_rail_compare,
    output logic o_analog_rail_compare
);
    // 4630, 3080, 2930 and 2630 mV
    localparam logic [15:0] TRIP [4] = '{16'h1216, 16'h0c08, 16'h0b72, 16'h0a46};
    // high above trip; a disabled comparator idles high
    assign o_digital_rail_compare = !i_monitor_enable || i_dig_mv > TRIP[i_digital_trip_sel];
    assign o_analog_rail_compare = !i_monitor_enable || i_ana_mv > TRIP[i_analog_trip_sel];
endmodule

// ===== smf_pkg.sv
// package: register address, field positions, reset value and timing counts for the supply monitor
package smf_pkg;
    // register address on the special function register bus
    localparam logic [7:0] SMF_CTRL_ADDR = 8'hdf;
    localparam logic [7:0] SMF_CTRL_RESET = 8'hde;
    // field positions
    localparam int SMF_BIT_DIG_CMP = 7;
    localparam int SMF_BIT_ANA_CMP = 6;
    localparam int SMF_BIT_IRQ_FLAG = 5;
    localparam int SMF_BIT_DIG_TRIP_HI = 4;
    localparam int SMF_BIT_DIG_TRIP_LO = 3;
    localparam int SMF_BIT_ANA_TRIP_HI = 2;
    localparam int SMF_BIT_ANA_TRIP_LO = 1;
    localparam int SMF_BIT_ENABLE = 0;
    // trip select codes: 4.63 V, 3.08 V, 2.93 V, 2.63 V
    localparam logic [1:0] SMF_TRIP_4V63 = 2'h0;
    localparam logic [1:0] SMF_TRIP_3V08 = 2'h1;
    localparam logic [1:0] SMF_TRIP_2V93 = 2'h2;
    localparam logic [1:0] SMF_TRIP_2V63 = 2'h3;
    // timing
    localparam longint SMF_CLK_HZ = 40000000;
    localparam longint SMF_RECOVER_MS = 250;
    localparam longint SMF_RECOVER_CYC = (SMF_RECOVER_MS * SMF_CLK_HZ) / 1000;
    localparam int SMF_GLITCH_CYC = 8;
endpackage

// ===== smf_supply_monitor.sv
// module: supply monitor control register, low-supply flag and recovery timer
//
// Function
// RL1 - set low-supply flag bit 5 whenever either rail comparator reads low
// RL2 - both comparators high start 250 ms count; expiry clears the flag
// RL3 - a comparator low during the count abandons it; restart when both high
// RL4 - software writes the flag, but clearing is ignored while any comparator low
// RL5 - bit 7 live digital comparator, bit 6 live analogue comparator, read-only
// RL6 - bits 4:3 select digital trip point 4.63/3.08/2.93/2.63 V
// RL7 - bits 2:1 select analogue trip point with the same encoding
// RL8 - bit 0 enables the monitor circuit
// RL9 - flag requests interrupt only when the external enable bit is set
// RL10 - short comparator glitches are filtered and cannot set the flag
// RL11 - reset value of the register is DEH; comparator bits stay live
// RL12 - each comparator output passes a two-stage synchroniser first
`timescale 1ns/1ps
module smf_supply_monitor #(
    parameter longint RECOVER_CYC = smf_pkg::SMF_RECOVER_CYC,
    parameter int GLITCH_CYC = smf_pkg::SMF_GLITCH_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // special function register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // comparators, asynchronous
    input wire logic i_digital_rail_compare,
    input wire logic i_analog_rail_compare,
    // comparator control
    output logic o_monitor_enable,
    output logic [1:0] o_digital_trip_sel,
    output logic [1:0] o_analog_trip_sel,
    // interrupt
    input wire logic i_secondary_irq_enable_priority,
    output logic o_low_supply_irq
);
    import smf_pkg::*;

    localparam int TW = $clog2(RECOVER_CYC + 1);

    // ****************************************
    // parameter checks
    // ****************************************
    // a zero count would clear the flag at once or let every glitch through
    if (RECOVER_CYC < 1)
    begin
        $error("smf_supply_monitor: RECOVER_CYC must be at least 1");
    end
    if (GLITCH_CYC < 1)
    begin
        $error("smf_supply_monitor: GLITCH_CYC must be at least 1");
    end

    typedef enum logic [1:0] {
        SMF_ST_IDLE,
        SMF_ST_LOW,
        SMF_ST_RECOVER
    } smf_state_e;

    typedef struct packed {
        smf_state_e state;
        logic [TW-1:0] timer;
        logic flag;
        logic [1:0] dig_trip;
        logic [1:0] ana_trip;
        logic enable;
        logic [7:0] rdata;
        logic hit;
        logic irq;
    } smf_st_s;

    smf_st_s st_ff;
    smf_st_s nxt_st;

    logic dig_sync;
    logic ana_sync;
    logic dig_filt;
    logic ana_filt;
    logic any_low;
    logic sel;
    logic [7:0] reg_view;

    // ****************************************
    // comparator conditioning
    // ****************************************
    smf_cmp_filter #(
        .FILT_CYC(GLITCH_CYC)
    ) u_dig_filter (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_cmp_async(i_digital_rail_compare),
        .o_sync(dig_sync),
        .o_filt(dig_filt)
    );

    smf_cmp_filter #(
        .FILT_CYC(GLITCH_CYC)
    ) u_ana_filter (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_cmp_async(i_analog_rail_compare),
        .o_sync(ana_sync),
        .o_filt(ana_filt)
    );

    // ****************************************
    // register and flag logic
    // ****************************************
    always_comb
    begin
        // filtered levels drive the flag so a glitch never sets it
        any_low = !dig_filt || !ana_filt;
        sel = (i_sfr_addr == SMF_CTRL_ADDR);
        reg_view = '0;
        // RL5 live comparator bits
        reg_view[SMF_BIT_DIG_CMP] = dig_sync;
        reg_view[SMF_BIT_ANA_CMP] = ana_sync;
        reg_view[SMF_BIT_IRQ_FLAG] = st_ff.flag;
        reg_view[SMF_BIT_DIG_TRIP_HI:SMF_BIT_DIG_TRIP_LO] = st_ff.dig_trip;
        reg_view[SMF_BIT_ANA_TRIP_HI:SMF_BIT_ANA_TRIP_LO] = st_ff.ana_trip;
        reg_view[SMF_BIT_ENABLE] = st_ff.enable;

        nxt_st = st_ff;
        nxt_st.hit = sel && (i_sfr_rd || i_sfr_wr);
        nxt_st.rdata = (sel && i_sfr_rd) ? reg_view : 8'h00;

        if (sel && i_sfr_wr)
        begin
            // RL6 digital trip select
            nxt_st.dig_trip = i_sfr_wdata[SMF_BIT_DIG_TRIP_HI:SMF_BIT_DIG_TRIP_LO];
            // RL7 analogue trip select
            nxt_st.ana_trip = i_sfr_wdata[SMF_BIT_ANA_TRIP_HI:SMF_BIT_ANA_TRIP_LO];
            // RL8 monitor enable
            nxt_st.enable = i_sfr_wdata[SMF_BIT_ENABLE];
            // RL4 clear refused while a rail is low
            if (i_sfr_wdata[SMF_BIT_IRQ_FLAG] || !any_low)
                nxt_st.flag = i_sfr_wdata[SMF_BIT_IRQ_FLAG];
        end

        case (st_ff.state)
            SMF_ST_IDLE:
            begin
                if (any_low)
                    nxt_st.state = SMF_ST_LOW;
            end
            SMF_ST_LOW:
            begin
                // RL2 start recovery count
                if (!any_low)
                begin
                    nxt_st.state = SMF_ST_RECOVER;
                    nxt_st.timer = '0;
                end
            end
            SMF_ST_RECOVER:
            begin
                // RL3 abandon count on new low
                if (any_low)
                begin
                    nxt_st.state = SMF_ST_LOW;
                end
                else if (st_ff.timer == TW'(RECOVER_CYC - 1))
                begin
                    // RL2 auto clear on expiry
                    nxt_st.state = SMF_ST_IDLE;
                    nxt_st.flag = 1'b0;
                end
                else
                begin
                    nxt_st.timer = st_ff.timer + TW'(1);
                end
            end
            default:
            begin
                nxt_st.state = SMF_ST_IDLE;
            end
        endcase

        // RL1 set wins over any clear
        if (any_low)
            nxt_st.flag = 1'b1;

        // RL9 gated interrupt request
        nxt_st.irq = nxt_st.flag && i_secondary_irq_enable_priority;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            // RL11 reset value DEH
            st_ff.state <= SMF_ST_IDLE;
            st_ff.timer <= '0;
            st_ff.flag <= SMF_CTRL_RESET[SMF_BIT_IRQ_FLAG];
            st_ff.dig_trip <= SMF_CTRL_RESET[SMF_BIT_DIG_TRIP_HI:SMF_BIT_DIG_TRIP_LO];
            st_ff.ana_trip <= SMF_CTRL_RESET[SMF_BIT_ANA_TRIP_HI:SMF_BIT_ANA_TRIP_LO];
            st_ff.enable <= SMF_CTRL_RESET[SMF_BIT_ENABLE];
            st_ff.rdata <= 8'h00;
            st_ff.hit <= 1'b0;
            st_ff.irq <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_sfr_rdata = st_ff.rdata;
    assign o_sfr_hit = st_ff.hit;
    assign o_monitor_enable = st_ff.enable;
    assign o_digital_trip_sel = st_ff.dig_trip;
    assign o_analog_trip_sel = st_ff.ana_trip;
    assign o_low_supply_irq = st_ff.irq;
endmodule

// ===== smf_supply_monitor_sva.sv
// checker: bus timing, field and flag relations of the supply monitor
`timescale 1ns/1ps
module smf_chk (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sfr_hit,
    input wire logic i_digital_rail_compare,
    input wire logic i_analog_rail_compare,
    input wire logic o_monitor_enable,
    input wire logic [1:0] o_digital_trip_sel,
    input wire logic [1:0] o_analog_trip_sel,
    input wire logic i_secondary_irq_enable_priority,
    input wire logic o_low_supply_irq
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    logic acc;
    assign acc = (i_sfr_wr || i_sfr_rd) && i_sfr_addr == 8'hdf;
    a_hit_on_access: assert property (acc |=> o_sfr_hit)
        else $error("no hit after access");
    a_hit_idle_low: assert property (!acc |=> !o_sfr_hit)
        else $error("hit without access");
    a_rdata_idle_zero: assert property (!o_sfr_hit |-> o_sfr_rdata == 8'h00)
        else $error("read data outside read");
    a_write_sets_fields: assert property (i_sfr_wr && i_sfr_addr == 8'hdf |=>
        {o_digital_trip_sel, o_analog_trip_sel, o_monitor_enable} == $past(i_sfr_wdata[4:0]))
        else $error("fields differ from write");
    a_fields_hold_value: assert property (!(i_sfr_wr && i_sfr_addr == 8'hdf) |=>
        $stable({o_digital_trip_sel, o_analog_trip_sel, o_monitor_enable}))
        else $error("fields moved without write");
    a_irq_gate_off: assert property (!i_secondary_irq_enable_priority |=> !o_low_supply_irq)
        else $error("irq while disabled");
    a_dig_live_copy: assert property (acc && i_sfr_rd |=>
        o_sfr_rdata[7] == $past(i_digital_rail_compare, 3)) else $error("bit 7 not live");
    a_ana_live_copy: assert property (acc && i_sfr_rd |=>
        o_sfr_rdata[6] == $past(i_analog_rail_compare, 3)) else $error("bit 6 not live");
    // filter length of 4 assumed, so eight low samples must raise the flag;
    // the enable must still stand on the edge that registers the request
    a_low_sets_irq: assert property ((!i_digital_rail_compare &&
        i_secondary_irq_enable_priority)[*8] ##1 i_secondary_irq_enable_priority
        |=> o_low_supply_irq) else $error("no irq");
    cover property (acc && i_sfr_wr);
    cover property ($rose(o_low_supply_irq));
    cover property ($fell(o_low_supply_irq));
endmodule
bind smf_supply_monitor smf_chk smf_chk_i (.*);

// ===== smf_supply_monitor_tb_top.sv
// testbench: register access, low-supply flag, filter and recovery timer
`timescale 1ns/1ps
module smf_supply_monitor_tb_top;
    import smf_pkg::*;
    // short recovery so the run stays brief
    localparam int REC = 30;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic irq_en = 1'b1;
    logic [15:0] dmv = 16'h1388;
    logic [15:0] amv = 16'h1388;
    logic [7:0] rdata;
    logic [7:0] rq;
    logic hit, en, irq, dcmp, acmp;
    logic [1:0] dsel, asel;
    int err_count = 0;
    int n_checks = 0;
    int cyc;
    always #12.5 i_core_clk = ~i_core_clk;
    smf_supply_monitor #(.RECOVER_CYC(REC), .GLITCH_CYC(4)) smf_supply_monitor_i (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_digital_rail_compare(dcmp), .i_analog_rail_compare(acmp), .o_monitor_enable(en),
        .o_digital_trip_sel(dsel), .o_analog_trip_sel(asel),
        .i_secondary_irq_enable_priority(irq_en), .o_low_supply_irq(irq));
    smf_cmp_model smf_cmp_model_i (.i_monitor_enable(en), .i_digital_trip_sel(dsel),
        .i_analog_trip_sel(asel), .i_dig_mv(dmv), .i_ana_mv(amv),
        .o_digital_rail_compare(dcmp), .o_analog_rail_compare(acmp));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #2;
    endtask
    // one access; hit must follow only at the control register
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        step(1);
        rq = rdata;
        chk({7'h00, hit}, {7'h00, a == 8'hdf});
        wr = 1'b0;
        rd = 1'b0;
        // idle edge so a following call never re-raises a strobe in this time step
        step(1);
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        acc(1'b0, 8'hdf, 8'h00);
        chk(rq, exp);
    endtask
    task automatic wait_irq(input logic v);
        cyc = 0;
        while (irq !== v && cyc < 80)
        begin
            step(1);
            cyc++;
        end
        chk({7'h00, irq}, {7'h00, v});
        if (irq !== v)
            end_sim();
    endtask
    task automatic t_fields();
        chk({2'b00, en, dsel, asel, irq}, 8'h1e);
        rd_chk(8'hde);
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, 8'hdf, {3'b000, k[1:0], k[1:0], k[0]});
            chk({3'b000, dsel, asel, en}, {3'b000, k[1:0], k[1:0], k[0]});
        end
        acc(1'b1, 8'h5a, 8'h00);
        rd_chk(8'hdf);
    endtask
    task automatic t_low();
        acc(1'b1, 8'hdf, 8'h09);
        dmv = 16'h0bb8;
        step(2);
        dmv = 16'h1388;
        step(15);
        chk({7'h00, irq}, 8'h00);
        dmv = 16'h0bb8;
        wait_irq(1'b1);
        rd_chk(8'h69);
        acc(1'b1, 8'hdf, 8'h09);
        rd_chk(8'h69);
        irq_en = 1'b0;
        step(2);
        chk({7'h00, irq}, 8'h00);
        irq_en = 1'b1;
    endtask
    task automatic t_recover();
        dmv = 16'h1388;
        step(20);
        dmv = 16'h0bb8;
        step(10);
        chk({7'h00, irq}, 8'h01);
        dmv = 16'h1388;
        wait_irq(1'b0);
        chk({7'h00, cyc >= REC + 4 && cyc <= REC + 12}, 8'h01);
        amv = 16'h11f8;
        wait_irq(1'b1);
        rd_chk(8'ha9);
        amv = 16'h1388;
        wait_irq(1'b0);
        acc(1'b1, 8'hdf, 8'h29);
        chk({7'h00, irq}, 8'h01);
        acc(1'b1, 8'hdf, 8'h09);
        chk({7'h00, irq}, 8'h00);
    endtask
    initial
    begin
        step(3);
        i_rst_b = 1'b1;
        t_fields();
        t_low();
        t_recover();
        end_sim();
    end
endmodule
